// file: burst_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module burst_fifo #(
	parameter int width = 8,
	parameter int depth = 8
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [width-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [width-1:0] out_data
);
	localparam int aw = $clog2(depth);

	logic [width-1:0] store [depth];
	logic [aw-1:0]    write_index;
	logic [aw-1:0]    read_index;
	logic [aw:0]      fill;
	logic             push;
	logic             pop;

	assign in_ready  = (fill != depth[aw:0]);
	assign out_valid = (fill != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = store[read_index];

	always_ff @(posedge clk) begin
		if (reset || (clk_en && flush)) begin
			write_index <= '0;
			read_index  <= '0;
			fill        <= '0;
		end else if (clk_en) begin
			if (push) begin
				write_index <= (write_index == aw'(depth - 1)) ? '0 : write_index + 1'b1;
			end
			if (pop) begin
				read_index <= (read_index == aw'(depth - 1)) ? '0 : read_index + 1'b1;
			end
			fill <= fill + (aw+1)'(push) - (aw+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en && push) begin
			store[write_index] <= in_data;
		end
	end
endmodule
`default_nettype wire

// file: serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
	import serial_port_pkg::*;
#(
	parameter int half = 16
) (
	input  wire logic clk,
	input  wire logic data_out,
	input  wire logic data_oe,
	output logic      port_select_n,
	output logic      serial_clock,
	output logic      data_in
);
	logic host_oe;
	logic host_bit;
	logic last;
	initial begin
		port_select_n = 1'b1;
		serial_clock = 1'b1;
		host_oe = 1'b0;
		host_bit = 1'b0;
	end
	// ==========================================================
	// Shared line: an undriven line shows the inverse of its last level.
	always_ff @(posedge clk) if (data_oe || host_oe) last <= data_in;
	assign data_in = data_oe ? data_out : (host_oe ? host_bit : ~last);
	// ==========================================================
	// Host transfers; clock idles high and stands still outside frames.
	task automatic frame(input bit open);
		repeat (4) @(posedge clk);
		port_select_n <= !open;
		host_oe <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task automatic shift(input logic [7:0] tx, input bit drive, input int n,
		output logic [7:0] rx);
		for (int i = 7; i > 7 - n; i--) begin
			@(posedge clk);
			serial_clock <= 1'b0;
			host_oe <= drive;
			host_bit <= tx[i];
			repeat (half) @(posedge clk);
			rx[i] = data_in;
			serial_clock <= 1'b1;
			repeat (half - 1) @(posedge clk);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input int gap);
		logic [7:0] rx;
		frame(1'b1);
		shift({1'b1, a}, 1'b1, 8, rx);
		shift(d, 1'b1, 8, rx);
		frame(1'b0);
		repeat (gap) @(posedge clk);
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d, input int n);
		frame(1'b1);
		shift({1'b0, a}, 1'b1, 8, d);
		repeat (read_address_data_delay_cycles) @(posedge clk);
		shift(8'h00, 1'b0, 8, d);
		if (n == 0) begin
			frame(1'b0);
			repeat (125) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// file: serial_port_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic hw_reset_n,
	input wire logic port_select_n,
	input wire logic serial_clock,
	input wire logic data_out,
	input wire logic data_oe,
	input wire logic illumination_oe,
	input wire logic illumination_low_current,
	input wire logic pixel_dump_write,
	input wire logic device_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ==========================================================
	// Sequences.
	sequence s_pin_low; !hw_reset_n [*3]; endsequence
	sequence s_running; (hw_reset_n && !device_reset) [*3]; endsequence
	sequence s_clock_high; (serial_clock && !port_select_n && data_oe) [*5]; endsequence
	// ==========================================================
	// Properties.
	property p_deselect_quiet; port_select_n [*5] |-> !data_oe; endproperty
	property p_drive_start; $rose(data_oe) |-> !port_select_n && !serial_clock; endproperty
	property p_hold_bit; s_clock_high |-> $stable(data_out); endproperty
	property p_pin_quiet; s_pin_low |=> !illumination_oe && !data_oe; endproperty
	property p_pin_full; s_pin_low |-> device_reset; endproperty
	property p_lamp_back; s_running |-> illumination_oe; endproperty
	property p_pd_sticky;
		illumination_low_current && !device_reset |=> illumination_low_current;
	endproperty
	property p_pd_exit; device_reset |=> !illumination_low_current; endproperty
	property p_soft_pulse; $rose(device_reset) && hw_reset_n |=> !device_reset; endproperty
	property p_dump_pulse; pixel_dump_write |=> !pixel_dump_write; endproperty
	a_deselect_quiet: assert property (p_deselect_quiet)
		else $error("data line driven while deselected");
	a_drive_start: assert property (p_drive_start)
		else $error("data drive began outside a falling clock phase");
	a_hold_bit: assert property (p_hold_bit)
		else $error("read bit changed while serial clock high");
	a_pin_quiet: assert property (p_pin_quiet)
		else $error("outputs driven during pin reset");
	a_pin_full: assert property (p_pin_full)
		else $error("pin reset did not reset the device");
	a_lamp_back: assert property (p_lamp_back)
		else $error("illumination output undriven after reset");
	a_pd_sticky: assert property (p_pd_sticky)
		else $error("power-down left without a reset");
	a_pd_exit: assert property (p_pd_exit)
		else $error("power-down kept through reset");
	a_soft_pulse: assert property (p_soft_pulse)
		else $error("soft reset longer than one cycle");
	a_dump_pulse: assert property (p_dump_pulse)
		else $error("pixel dump strobe longer than one cycle");
endmodule
`default_nettype wire

// file: serial_port_pkg.sv
package serial_port_pkg;

	// Register offsets.
	localparam logic [6:0] addr_part_identifier          = 7'h00;
	localparam logic [6:0] addr_silicon_revision         = 7'h01;
	localparam logic [6:0] addr_motion_flag_status       = 7'h02;
	localparam logic [6:0] addr_horizontal_displacement  = 7'h03;
	localparam logic [6:0] addr_vertical_displacement    = 7'h04;
	localparam logic [6:0] addr_surface_quality          = 7'h05;
	localparam logic [6:0] addr_exposure_time_high       = 7'h06;
	localparam logic [6:0] addr_exposure_time_low        = 7'h07;
	localparam logic [6:0] addr_brightest_pixel          = 7'h08;
	localparam logic [6:0] addr_pixel_total              = 7'h09;
	localparam logic [6:0] addr_darkest_pixel            = 7'h0a;
	localparam logic [6:0] addr_image_pixel_dump         = 7'h0b;
	localparam logic [6:0] addr_sensor_control           = 7'h0d;
	localparam logic [6:0] addr_soft_reset_trigger       = 7'h3a;
	localparam logic [6:0] addr_inverted_revision        = 7'h3f;
	localparam logic [6:0] addr_burst_readout_port       = 7'h63;

	// Field positions and values.
	localparam int         powerdown_bit                 = 1;
	localparam int         motion_flag_bit               = 7;
	localparam logic [7:0] soft_reset_key                = 8'h5a;
	localparam logic [7:0] sensor_control_reset          = 8'h00;
	localparam logic [7:0] motion_flag_reset             = 8'h00;
	localparam logic [7:0] burst_readout_value           = 8'h00;
	localparam logic [7:0] reserved_read_value           = 8'h00;
	localparam logic [2:0] burst_byte_count              = 3'h7;
	localparam logic [2:0] last_bit_index                = 3'h7;

	// Fifo shape for the burst output buffer.
	localparam int         burst_fifo_width              = 8;
	localparam int         burst_fifo_depth              = 8;

	// Host-side timing, kept for reference by the bench.
	localparam int         clk_period_ps                 = 4000;
	localparam int         write_write_gap_us            = 30;
	localparam int         write_read_gap_us             = 20;
	localparam int         read_address_data_delay_us    = 4;
	localparam int         read_read_gap_ns              = 500;
	localparam int         burst_exit_time_ns            = 250;
	localparam int         write_write_gap_cycles        = write_write_gap_us * 1000000 / clk_period_ps;
	localparam int         write_read_gap_cycles         = write_read_gap_us * 1000000 / clk_period_ps;
	localparam int         read_address_data_delay_cycles =
		read_address_data_delay_us * 1000000 / clk_period_ps;
	localparam int         burst_exit_time_cycles        = burst_exit_time_ns * 1000 / clk_period_ps;

	typedef enum logic [4:0] {
		st_idle    = 5'h01,
		st_address = 5'h02,
		st_write   = 5'h04,
		st_read    = 5'h08,
		st_locked  = 5'h10
	} port_state_e;

endpackage

// file: three_wire_sensor_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Chip select high: ignore clock and data, data line undriven.
// - Host starts every transfer and supplies the clock; device never initiates.
// - Chip select rising mid-transaction abandons it and idles the port.
// - Write: direction one, seven-bit address, then data; sampled on rising edge.
// - Read: address byte with direction zero, device drives data byte.
// - Read data changes on falling edges; inputs sampled on rising edges.
// - Read bit held until the next falling edge.
// - Burst address returns seven motion bytes in fixed order.
// - Chip select high ends a burst at any byte boundary.
// - Burst values captured at last address bit, shifted back to back.
// - After a burst, port refuses transfers until chip select rises.
// - Reset pin low or key write to soft reset register resets all.
// - During reset, pins ignored and illumination output undriven.
// - Control bit one enters power-down, left only by a full reset.
module three_wire_sensor_serial_port
	import serial_port_pkg::*;
#(
	parameter logic [7:0] part_identifier_value  = 8'h3c, // Arbitrary value.
	parameter logic [7:0] silicon_revision_value = 8'h05  // Arbitrary value.
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	input  wire logic       hw_reset_n,
	input  wire logic       port_select_n,
	input  wire logic       serial_clock,
	input  wire logic       data_in,
	output logic            data_out,
	output logic            data_oe,
	output logic            illumination_drive,
	output logic            illumination_oe,
	output logic            illumination_low_current,
	input  wire logic [7:0] horizontal_displacement,
	input  wire logic [7:0] vertical_displacement,
	input  wire logic [7:0] surface_quality,
	input  wire logic [7:0] exposure_time_high,
	input  wire logic [7:0] exposure_time_low,
	input  wire logic [7:0] brightest_pixel,
	input  wire logic [7:0] pixel_total,
	input  wire logic [7:0] darkest_pixel,
	input  wire logic [7:0] image_pixel_dump,
	input  wire logic       motion_event,
	input  wire logic       illumination_request,
	output logic            motion_read_clear,
	output logic            pixel_dump_write,
	output logic [7:0]      pixel_dump_data,
	output logic            device_reset
);
	// ==========================================================
	// Input synchronisers.
	// ==========================================================
	logic [1:0] sync_select_n;
	logic [1:0] sync_sclk;
	logic [1:0] sync_data;
	logic [1:0] sync_reset_n;
	logic       sclk_last;
	logic       select_n;
	logic       sclk_rise;
	logic       sclk_fall;

	always_ff @(posedge clk) begin
		if (reset) begin
			sync_select_n <= 2'h3;
			sync_sclk     <= 2'h3;
			sync_data     <= 2'h0;
			sync_reset_n  <= 2'h0;
			sclk_last     <= 1'b1;
		end else if (clk_en) begin
			sync_select_n <= {sync_select_n[0], port_select_n};
			sync_sclk     <= {sync_sclk[0], serial_clock};
			sync_data     <= {sync_data[0], data_in};
			sync_reset_n  <= {sync_reset_n[0], hw_reset_n};
			sclk_last     <= sync_sclk[1];
		end
	end

	assign select_n  = sync_select_n[1];
	assign sclk_rise = !select_n && sync_sclk[1] && !sclk_last;
	assign sclk_fall = !select_n && !sync_sclk[1] && sclk_last;

	// ==========================================================
	// Device reset: pin or soft-reset key.
	// ==========================================================
	logic soft_reset;
	logic full_reset;

	assign full_reset   = reset || !sync_reset_n[1] || soft_reset;
	assign device_reset = reset || !sync_reset_n[1] || soft_reset;

	// ==========================================================
	// Serial state machine.
	// ==========================================================
	port_state_e state;
	logic [7:0]  shift_in;
	logic [2:0]  bit_count;
	logic [6:0]  address;
	logic [7:0]  shift_out;
	logic        burst_mode;
	logic [2:0]  burst_left;
	logic        write_done;
	logic        read_start;
	logic [7:0]  next_shift_in;

	assign next_shift_in = {shift_in[6:0], sync_data[1]};
	assign write_done    = (state == st_write) && sclk_rise && (bit_count == last_bit_index);
	assign read_start    = (state == st_address) && sclk_rise
		&& (bit_count == last_bit_index) && !shift_in[6];

	always_ff @(posedge clk) begin
		if (full_reset) begin
			state     <= st_idle;
			bit_count <= '0;
			shift_in  <= '0;
			address   <= '0;
		end else if (clk_en) begin
			if (select_n) begin
				state     <= st_idle;
				bit_count <= '0;
			end else begin
				case (state)
					st_idle: begin
						state <= st_address;
					end
					st_address: begin
						if (sclk_rise) begin
							shift_in  <= next_shift_in;
							bit_count <= bit_count + 3'h1;
							if (bit_count == last_bit_index) begin
								address <= next_shift_in[6:0];
								state   <= next_shift_in[7] ? st_write : st_read;
							end
						end
					end
					st_write: begin
						if (sclk_rise) begin
							shift_in  <= next_shift_in;
							bit_count <= bit_count + 3'h1;
							if (bit_count == last_bit_index) begin
								state <= st_address;
							end
						end
					end
					st_read: begin
						if (sclk_rise) begin
							bit_count <= bit_count + 3'h1;
							if (bit_count == last_bit_index) begin
								if (burst_mode && burst_left == 3'h0) begin
									state <= st_locked;
								end else if (!burst_mode) begin
									state <= st_address;
								end
							end
						end
					end
					st_locked: begin
						state <= st_locked;
					end
					default: begin
						state <= st_idle;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Writable registers.
	// ==========================================================
	logic [7:0] sensor_control;
	logic       motion_flag;

	always_ff @(posedge clk) begin
		if (full_reset) begin
			sensor_control <= sensor_control_reset;
			soft_reset     <= 1'b0;
		end else if (clk_en) begin
			soft_reset <= 1'b0;
			if (write_done && !select_n) begin
				if (address == addr_sensor_control) begin
					sensor_control[powerdown_bit] <= sensor_control[powerdown_bit]
						| next_shift_in[powerdown_bit];
					sensor_control[7:2] <= next_shift_in[7:2];
					sensor_control[0]   <= next_shift_in[0];
				end
				if (address == addr_soft_reset_trigger && next_shift_in == soft_reset_key) begin
					soft_reset <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (full_reset) begin
			pixel_dump_write  <= 1'b0;
			pixel_dump_data   <= '0;
			motion_read_clear <= 1'b0;
		end else if (clk_en) begin
			pixel_dump_write  <= write_done && address == addr_image_pixel_dump;
			motion_read_clear <= write_done && address == addr_motion_flag_status;
			if (write_done && address == addr_image_pixel_dump) begin
				pixel_dump_data <= next_shift_in;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (full_reset) begin
			motion_flag <= motion_flag_reset[motion_flag_bit];
		end else if (clk_en) begin
			if (motion_event) begin
				motion_flag <= 1'b1;
			end else if (write_done && address == addr_motion_flag_status) begin
				motion_flag <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read mux.
	// ==========================================================
	function automatic logic [7:0] read_value(input logic [6:0] a);
		case (a)
			addr_part_identifier:         read_value = part_identifier_value;
			addr_silicon_revision:        read_value = silicon_revision_value;
			addr_motion_flag_status:      read_value = {motion_flag, 7'h00};
			addr_horizontal_displacement: read_value = horizontal_displacement;
			addr_vertical_displacement:   read_value = vertical_displacement;
			addr_surface_quality:         read_value = surface_quality;
			addr_exposure_time_high:      read_value = exposure_time_high;
			addr_exposure_time_low:       read_value = exposure_time_low;
			addr_brightest_pixel:         read_value = brightest_pixel;
			addr_pixel_total:             read_value = pixel_total;
			addr_darkest_pixel:           read_value = darkest_pixel;
			addr_image_pixel_dump:        read_value = image_pixel_dump;
			addr_sensor_control:          read_value = sensor_control;
			addr_inverted_revision:       read_value = ~silicon_revision_value;
			addr_burst_readout_port:      read_value = burst_readout_value;
			default:                      read_value = reserved_read_value;
		endcase
	endfunction

	// ==========================================================
	// Burst capture into the output buffer.
	// ==========================================================
	logic [7:0] burst_bytes [7];
	logic [2:0] load_index;
	logic       loading;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic       fifo_pop;
	logic [7:0] fifo_out_data;
	logic       burst_request;

	assign burst_request = read_start && next_shift_in[6:0] == addr_burst_readout_port;

	always_ff @(posedge clk) begin
		if (full_reset) begin
			loading    <= 1'b0;
			load_index <= '0;
			for (int i = 0; i < 7; i++) begin
				burst_bytes[i] <= '0;
			end
		end else if (clk_en) begin
			if (burst_request && !select_n) begin
				burst_bytes[0] <= horizontal_displacement;
				burst_bytes[1] <= vertical_displacement;
				burst_bytes[2] <= surface_quality;
				burst_bytes[3] <= exposure_time_high;
				burst_bytes[4] <= exposure_time_low;
				burst_bytes[5] <= brightest_pixel;
				burst_bytes[6] <= pixel_total;
				loading        <= 1'b1;
				load_index     <= '0;
			end else if (loading && fifo_in_ready) begin
				load_index <= load_index + 3'h1;
				if (load_index == burst_byte_count - 3'h1) begin
					loading <= 1'b0;
				end
			end
		end
	end

	burst_fifo #(
		.width (burst_fifo_width),
		.depth (burst_fifo_depth)
	) output_buffer (
		.clk       (clk),
		.reset     (full_reset),
		.clk_en    (clk_en),
		.flush     (select_n),
		.in_valid  (loading),
		.in_ready  (fifo_in_ready),
		.in_data   (burst_bytes[load_index]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// ==========================================================
	// Read data shifter, driven on falling edges.
	// ==========================================================
	logic byte_loaded;

	assign fifo_pop = burst_mode && fifo_out_valid && !byte_loaded && !select_n;

	always_ff @(posedge clk) begin
		if (full_reset) begin
			shift_out   <= '0;
			burst_mode  <= 1'b0;
			burst_left  <= '0;
			byte_loaded <= 1'b0;
			data_out    <= 1'b0;
		end else if (clk_en) begin
			if (select_n) begin
				burst_mode  <= 1'b0;
				byte_loaded <= 1'b0;
			end else begin
				if (read_start) begin
					burst_mode  <= burst_request;
					burst_left  <= burst_byte_count - 3'h1;
					byte_loaded <= !burst_request;
					shift_out   <= read_value(next_shift_in[6:0]);
				end else if (fifo_pop) begin
					shift_out   <= fifo_out_data;
					byte_loaded <= 1'b1;
				end
				if (state == st_read && sclk_fall && byte_loaded) begin
					data_out  <= shift_out[7];
					shift_out <= {shift_out[6:0], 1'b0};
				end
				if (state == st_read && sclk_rise && bit_count == last_bit_index) begin
					byte_loaded <= 1'b0;
					if (burst_mode && burst_left != 3'h0) begin
						burst_left <= burst_left - 3'h1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (full_reset) begin
			data_oe <= 1'b0;
		end else if (clk_en) begin
			if (select_n) begin
				data_oe <= 1'b0;
			end else if (state == st_read && sclk_fall) begin
				data_oe <= 1'b1;
			end else if (state != st_read && sclk_fall) begin
				data_oe <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Illumination and power-down.
	// ==========================================================
	always_ff @(posedge clk) begin
		if (full_reset) begin
			illumination_oe          <= 1'b0;
			illumination_drive       <= 1'b0;
			illumination_low_current <= 1'b0;
		end else if (clk_en) begin
			illumination_oe          <= 1'b1;
			illumination_low_current <= sensor_control[powerdown_bit];
			illumination_drive       <= illumination_request && !sensor_control[powerdown_bit];
		end
	end
endmodule
`default_nettype wire

// file: three_wire_sensor_serial_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module three_wire_sensor_serial_port_tb_top
	import serial_port_pkg::*;
;
	logic clk, reset, hw_reset_n, motion_event, illumination_request;
	logic port_select_n, serial_clock, data_in, data_out, data_oe;
	logic illumination_oe, illumination_low_current, motion_read_clear;
	logic pixel_dump_write, device_reset, illumination_drive;
	logic [7:0] pixel_dump_data, dump_seen, d;
	logic [7:0] mv [0:8];
	int error_cnt, comparisons, dump_cnt, clear_cnt, rst_cnt, oe_cnt;
	three_wire_sensor_serial_port u_three_wire_sensor_serial_port (
		.clk(clk), .reset(reset), .clk_en(1'b1), .hw_reset_n(hw_reset_n),
		.port_select_n(port_select_n), .serial_clock(serial_clock), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .illumination_drive(illumination_drive),
		.illumination_oe(illumination_oe), .illumination_low_current(illumination_low_current),
		.horizontal_displacement(mv[0]), .vertical_displacement(mv[1]),
		.surface_quality(mv[2]), .exposure_time_high(mv[3]), .exposure_time_low(mv[4]),
		.brightest_pixel(mv[5]), .pixel_total(mv[6]), .darkest_pixel(mv[7]),
		.image_pixel_dump(mv[8]), .motion_event(motion_event),
		.illumination_request(illumination_request), .motion_read_clear(motion_read_clear),
		.pixel_dump_write(pixel_dump_write), .pixel_dump_data(pixel_dump_data),
		.device_reset(device_reset));
	serial_host_model u_serial_host_model (.clk(clk), .data_out(data_out), .data_oe(data_oe),
		.port_select_n(port_select_n), .serial_clock(serial_clock), .data_in(data_in));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========================================================
	// Monitors of design strobes.
	always @(posedge clk) begin
		if (pixel_dump_write === 1'b1) begin
			dump_cnt++;
			dump_seen = pixel_dump_data;
		end
		if (motion_read_clear === 1'b1) clear_cnt++;
		if (device_reset === 1'b1 && hw_reset_n === 1'b1) rst_cnt++;
		if (data_oe === 1'b1) oe_cnt++;
	end
	// ==========================================================
	// Comparison and closing.
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
		u_serial_host_model.rd(a, d, 0);
		check8("read data", exp, d);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
	// ==========================================================
	// Test sequence.
	initial begin
		reset = 1'b1;
		hw_reset_n = 1'b1;
		motion_event = 1'b0;
		illumination_request = 1'b1;
		for (int i = 0; i < 9; i++) mv[i] = 8'h81 + 8'(i * 19);
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		rst_cnt = 0;
		rchk(addr_part_identifier, 8'h3c);
		rchk(addr_silicon_revision, 8'h05);
		rchk(addr_inverted_revision, 8'hfa);
		rchk(addr_motion_flag_status, 8'h00);
		rchk(addr_sensor_control, 8'h00);
		rchk(7'h0c, reserved_read_value);
		for (int i = 0; i < 9; i++) rchk(7'(7'h03 + i), mv[i]);
		@(posedge clk) motion_event <= 1'b1;
		@(posedge clk) motion_event <= 1'b0;
		rchk(addr_motion_flag_status, 8'h80);
		u_serial_host_model.wr(addr_motion_flag_status, 8'h00, write_read_gap_cycles);
		check8("clear strobes", 8'd1, 8'(clear_cnt));
		rchk(addr_motion_flag_status, 8'h00);
		u_serial_host_model.wr(addr_image_pixel_dump, 8'ha5, write_read_gap_cycles);
		check8("dump strobes", 8'd1, 8'(dump_cnt));
		check8("dump data", 8'ha5, dump_seen);
		u_serial_host_model.wr(addr_part_identifier, 8'h77, write_read_gap_cycles);
		rchk(addr_part_identifier, 8'h3c);
		u_serial_host_model.frame(1'b1);
		u_serial_host_model.shift(8'h80, 1'b1, 4, d);
		u_serial_host_model.frame(1'b0);
		repeat (read_address_data_delay_cycles) @(posedge clk);
		rchk(addr_silicon_revision, 8'h05);
		u_serial_host_model.rd(addr_burst_readout_port, d, 1);
		check8("burst byte", mv[0], d);
		for (int i = 1; i < 7; i++) begin
			u_serial_host_model.shift(8'h00, 1'b0, 8, d);
			check8("burst byte", mv[i], d);
		end
		repeat (8) @(posedge clk);
		u_serial_host_model.shift({1'b0, addr_part_identifier}, 1'b1, 8, d);
		oe_cnt = 0;
		u_serial_host_model.shift(8'h00, 1'b0, 8, d);
		check8("locked drive cycles", 8'd0, 8'(oe_cnt));
		u_serial_host_model.frame(1'b0);
		repeat (burst_exit_time_cycles) @(posedge clk);
		u_serial_host_model.rd(addr_burst_readout_port, d, 1);
		u_serial_host_model.shift(8'h00, 1'b0, 8, d);
		check8("short burst", mv[1], d);
		u_serial_host_model.frame(1'b0);
		repeat (burst_exit_time_cycles) @(posedge clk);
		rchk(addr_silicon_revision, 8'h05);
		u_serial_host_model.wr(addr_soft_reset_trigger, 8'h33, write_write_gap_cycles);
		check8("soft resets", 8'd0, 8'(rst_cnt));
		u_serial_host_model.wr(addr_sensor_control, 8'h02, write_write_gap_cycles);
		check8("low current", 8'h01, {7'h00, illumination_low_current});
		check8("lamp drive", 8'h00, {7'h00, illumination_drive});
		u_serial_host_model.wr(addr_soft_reset_trigger, soft_reset_key, 100);
		check8("soft resets", 8'd1, 8'(rst_cnt));
		check8("low current", 8'h00, {7'h00, illumination_low_current});
		rchk(addr_sensor_control, 8'h00);
		u_serial_host_model.wr(addr_sensor_control, 8'h02, 100);
		hw_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		check8("lamp enable", 8'h00, {7'h00, illumination_oe});
		hw_reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		check8("lamp enable", 8'h01, {7'h00, illumination_oe});
		check8("low current", 8'h00, {7'h00, illumination_low_current});
		check8("lamp drive", 8'h01, {7'h00, illumination_drive});
		give_verdict();
	end
endmodule
bind three_wire_sensor_serial_port serial_port_checker u_serial_port_checker (
	.clk(clk), .reset(reset), .hw_reset_n(hw_reset_n), .port_select_n(port_select_n),
	.serial_clock(serial_clock), .data_out(data_out), .data_oe(data_oe),
	.illumination_oe(illumination_oe), .illumination_low_current(illumination_low_current),
	.pixel_dump_write(pixel_dump_write), .device_reset(device_reset));
`default_nettype wire
